// File: design/card_ctrl_pkg.sv
// ============================================================
// Shared constants for the system control and pin routing block.
package card_ctrl_pkg;

  // ============================================================
  // Register offsets in configuration space.
  localparam logic [7:0]  SYSCTL_OFS        = 8'h80;
  localparam logic [7:0]  ROUTING_OFS       = 8'h8C;

  // ============================================================
  // System control field positions, low half.
  localparam int          SC_STREAM_BIT     = 11;
  localparam int          SC_UP_BIT         = 10;
  localparam int          SC_DOWN_BIT       = 9;
  localparam int          SC_PROBE_BIT      = 8;
  localparam int          SC_AUTO_BIT       = 7;
  localparam int          SC_GATING_BIT     = 6;
  localparam int          SC_LOCK_BIT       = 5;
  localparam int          SC_PARITY_BIT     = 4;
  localparam int          SC_VOLT_BIT       = 2;
  localparam int          SC_KEEP_BIT       = 1;
  localparam int          SC_MUX_BIT        = 0;
  localparam logic [7:0]  SC_CTRL_RESET     = 8'h20;

  // ============================================================
  // Pin routing reset value and writable mask (top nibble reads zero).
  localparam logic [31:0] ROUTING_RESET     = 32'h0000_1000;
  localparam logic [31:0] ROUTING_RW_MASK   = 32'h0FFF_FFFF;

  // ============================================================
  // Timing: clock period and power switch sequencing times.
  localparam int          CLK_PERIOD_NS     = 40;
  localparam int          STREAM_NS         = 1280;
  localparam int          STREAM_CYC        = (STREAM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          UP_SETTLE_NS      = 1000000;
  localparam int          UP_SETTLE_CYC     = (UP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          DOWN_SETTLE_NS    = 500000;
  localparam int          DOWN_SETTLE_CYC   = (DOWN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SETTLE_CNT_W      = 16;

  // ============================================================
  // Power sequencer states.
  typedef enum logic [3:0] {
    SEQ_IDLE   = 4'h1,
    SEQ_STREAM = 4'h2,
    SEQ_UP     = 4'h4,
    SEQ_DOWN   = 4'h8
  } seq_state_t;

  // Returns true when an access address selects the given register.
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr[7:2] == ofs[7:2]);
  endfunction : reg_hit

endpackage : card_ctrl_pkg

// File: design/pwr_seq_if.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Link between the register bank and the power sequencer.
interface pwr_seq_if;
  logic up_req;
  logic down_req;
  logic stream_busy;
  logic up_busy;
  logic down_busy;

  modport ctl (output up_req, output down_req,
               input stream_busy, input up_busy, input down_busy);
  modport seq (input up_req, input down_req,
               output stream_busy, output up_busy, output down_busy);
endinterface : pwr_seq_if
`default_nettype wire

// File: design/pwr_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Power switch sequencer: stream, then settle delay.
module pwr_sequencer
  import card_ctrl_pkg::*;
#(
  parameter int unsigned UP_CYC   = UP_SETTLE_CYC,
  parameter int unsigned DOWN_CYC = DOWN_SETTLE_CYC
) (
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Sequencer link.
  pwr_seq_if.seq    sif
);

  seq_state_t              state_q, state_d;
  logic [SETTLE_CNT_W-1:0] cnt_q,   cnt_d;
  logic                    dir_up_q, dir_up_d;

  // Next state: a request starts a stream, the stream leads into a settle delay.
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    dir_up_d = dir_up_q;
    unique case (state_q)
      SEQ_IDLE: begin
        if (sif.up_req || sif.down_req) begin
          state_d  = SEQ_STREAM;
          dir_up_d = sif.up_req;
          cnt_d    = SETTLE_CNT_W'(STREAM_CYC - 1);
        end
      end
      SEQ_STREAM: begin
        if (cnt_q == '0) begin
          state_d = dir_up_q ? SEQ_UP : SEQ_DOWN;
          cnt_d   = dir_up_q ? SETTLE_CNT_W'(UP_CYC - 1) : SETTLE_CNT_W'(DOWN_CYC - 1);
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      SEQ_UP, SEQ_DOWN: begin
        if (cnt_q == '0) begin
          state_d = SEQ_IDLE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: state_d = SEQ_IDLE;
    endcase
  end

  // State registers.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q  <= SEQ_IDLE;
      cnt_q    <= '0;
      dir_up_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      dir_up_q <= dir_up_d;
    end
  end

  // Busy flags decoded from the one-hot state.
  assign sif.stream_busy = state_q[1];
  assign sif.up_busy     = state_q[2];
  assign sif.down_busy   = state_q[3];

  // ============================================================
  // Checks.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_stream_start: assert property ((state_q == SEQ_IDLE) && (sif.up_req || sif.down_req)
    |=> sif.stream_busy [*8]) else $error("stream did not start or stopped early");
  a_up_follows: assert property ($fell(sif.stream_busy) && dir_up_q |-> sif.up_busy)
    else $error("power-up settle not entered after stream");
  a_down_follows: assert property ($fell(sif.stream_busy) && !dir_up_q |-> sif.down_busy)
    else $error("power-down settle not entered after stream");
  a_settle_end: assert property ((sif.up_busy || sif.down_busy) && cnt_q == '0
    |=> state_q == SEQ_IDLE) else $error("settle busy did not clear at expiry");

  c_up_cycle: cover property ($fell(sif.up_busy));
  c_down_cycle: cover property ($fell(sif.down_busy));

endmodule : pwr_sequencer
`default_nettype wire

// File: design/card_sysctl_routing.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// System control low half and pin routing register bank.

// Summary of operation
// - Power-up settle busy is set after a power-up stream and clears when its delay expires.
// - Power-down settle busy is set after a power-down stream and clears when its delay expires.
// - Card probe busy reads 1 while interrogation runs, 0 otherwise and after reset.
// - The auto switch gate enables the legacy automatic power switch function, off by default.
// - With idle clock gating on, an inserted idle card with stopped clock stops its state clock.
// - The identity write lock makes the identity registers read-only at 1, its default.
// - Card parity errors reach the system error output only while parity reporting is on.
// - Socket voltage select picks 3.3 V at 0 and 5 V at 1.
// - Clock stop inhibit at 1 forbids stopping either clock through clock-run.
// - With the pin select at 0 ring and wake share the pin and ring wins when both are enabled.
// - With the pin select at 1 only the wake event drives the shared pin.
// - The routing register at 8Ch resets to 0000 1000h, all terminals general inputs.
// - A serial EEPROM load may replace the routing register contents at initialization.
// - Switch stream busy is set while a power stream is sent and cleared when it ends.
module card_sysctl_routing
  import card_ctrl_pkg::*;
#(
  parameter int unsigned UP_CYC   = UP_SETTLE_CYC,
  parameter int unsigned DOWN_CYC = DOWN_SETTLE_CYC
) (
  // Clock and reset.
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  // Configuration access port.
  input  wire logic        cfg_wr_in,
  input  wire logic        cfg_rd_in,
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic [3:0]  cfg_be_in,
  input  wire logic [31:0] cfg_wdata_in,
  output logic      [31:0] cfg_rdata_out,
  output logic             cfg_rvalid_out,
  // Power and interrogation events.
  input  wire logic        pwr_up_req_in,
  input  wire logic        pwr_down_req_in,
  input  wire logic        probe_start_in,
  input  wire logic        probe_done_in,
  // Card state and controls.
  input  wire logic        legacy_auto_switch_in,
  input  wire logic        card_inserted_in,
  input  wire logic        card_idle_in,
  input  wire logic        card_clk_stopped_in,
  input  wire logic        card_parity_err_in,
  output logic             auto_switch_en_out,
  output logic             cb_sm_clk_en_out,
  output logic             identity_wr_en_out,
  output logic             serr_parity_out,
  output logic             socket_voltage_select_out,
  output logic             clock_stop_inhibit_out,
  // Ring and wake terminal.
  input  wire logic        ring_indicate_output_in,
  input  wire logic        ring_en_in,
  input  wire logic        pme_in,
  input  wire logic        pme_en_in,
  output logic             ring_wake_pin_out,
  // Serial EEPROM load and routing output.
  input  wire logic        eeprom_load_in,
  input  wire logic [31:0] eeprom_data_in,
  output logic      [31:0] pin_routing_out
);

  // ============================================================
  // Reset release through two flip-flops.
  logic rst_meta_q;
  logic rst_n_q;

  // Synchronises the release of the external reset.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ============================================================
  // Power sequencer.
  pwr_seq_if seq_link ();

  // Power change requests go straight to the sequencer.
  assign seq_link.up_req   = pwr_up_req_in;
  assign seq_link.down_req = pwr_down_req_in;

  pwr_sequencer #(
    .UP_CYC   (UP_CYC),
    .DOWN_CYC (DOWN_CYC)
  ) u_seq (
    .clk_in   (clk_sys_in),
    .rst_n_in (rst_n_q),
    .sif      (seq_link.seq)
  );

  // ============================================================
  // Register state.
  logic [7:0]  ctrl_q,    ctrl_d;
  logic        probe_q,   probe_d;
  logic [31:0] routing_q, routing_d;
  logic        sc_wr;
  logic        rt_wr;

  assign sc_wr = cfg_wr_in && reg_hit(cfg_addr_in, SYSCTL_OFS);
  assign rt_wr = cfg_wr_in && reg_hit(cfg_addr_in, ROUTING_OFS);

  // Next register values; status bits take no host writes.
  always_comb begin
    ctrl_d    = ctrl_q;
    routing_d = routing_q;
    if (sc_wr && cfg_be_in[0]) begin
      ctrl_d = cfg_wdata_in[7:0];
    end
    probe_d = probe_start_in || (probe_q && !probe_done_in);
    for (int i = 0; i < 4; i++) begin
      if (rt_wr && cfg_be_in[i]) begin
        routing_d[8*i +: 8] = cfg_wdata_in[8*i +: 8];
      end
    end
    if (eeprom_load_in) begin
      routing_d = eeprom_data_in;
    end
    routing_d = routing_d & ROUTING_RW_MASK;
  end

  // Register file flip-flops.
  always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q    <= SC_CTRL_RESET;
      probe_q   <= 1'b0;
      routing_q <= ROUTING_RESET;
    end else begin
      ctrl_q    <= ctrl_d;
      probe_q   <= probe_d;
      routing_q <= routing_d;
    end
  end

  // ============================================================
  // Derived controls and read port.
  logic [31:0] rdata_d;
  logic        auto_d;
  logic        clk_en_d;
  logic        serr_d;
  logic        pin_d;
  logic [11:0] sysctl_view;

  assign sysctl_view = {seq_link.stream_busy, seq_link.up_busy,
                        seq_link.down_busy, probe_q, ctrl_q};

  // Computes the auto switch, clock enable, parity and shared pin controls and the read answer.
  always_comb begin
    auto_d   = ctrl_q[SC_AUTO_BIT] && legacy_auto_switch_in;
    clk_en_d = !(ctrl_q[SC_GATING_BIT] && card_inserted_in &&
                 card_idle_in && card_clk_stopped_in);
    serr_d   = ctrl_q[SC_PARITY_BIT] && card_parity_err_in;
    if (ctrl_q[SC_MUX_BIT]) begin
      pin_d = pme_in;
    end else if (ring_en_in) begin
      pin_d = ring_indicate_output_in;
    end else begin
      pin_d = pme_en_in && pme_in;
    end
    rdata_d = 32'h0000_0000;
    if (reg_hit(cfg_addr_in, SYSCTL_OFS)) begin
      rdata_d = {20'h0_0000, sysctl_view};
    end else if (reg_hit(cfg_addr_in, ROUTING_OFS)) begin
      rdata_d = routing_q;
    end
  end

  // Output flip-flops.
  always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_rdata_out             <= 32'h0000_0000;
      cfg_rvalid_out            <= 1'b0;
      auto_switch_en_out        <= 1'b0;
      cb_sm_clk_en_out          <= 1'b1;
      identity_wr_en_out        <= 1'b0;
      serr_parity_out           <= 1'b0;
      socket_voltage_select_out <= 1'b0;
      clock_stop_inhibit_out    <= 1'b0;
      ring_wake_pin_out         <= 1'b0;
      pin_routing_out           <= ROUTING_RESET;
    end else begin
      cfg_rdata_out             <= cfg_rd_in ? rdata_d : 32'h0000_0000;
      cfg_rvalid_out            <= cfg_rd_in;
      auto_switch_en_out        <= auto_d;
      cb_sm_clk_en_out          <= clk_en_d;
      identity_wr_en_out        <= !ctrl_q[SC_LOCK_BIT];
      serr_parity_out           <= serr_d;
      socket_voltage_select_out <= ctrl_q[SC_VOLT_BIT];
      clock_stop_inhibit_out    <= ctrl_q[SC_KEEP_BIT];
      ring_wake_pin_out         <= pin_d;
      pin_routing_out           <= routing_q;
    end
  end

  // ============================================================
  // Checks.
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_q);

  a_probe_status: assert property (probe_start_in ##1 cfg_rd_in &&
    reg_hit(cfg_addr_in, SYSCTL_OFS) |=> cfg_rdata_out[SC_PROBE_BIT])
    else $error("probe busy not visible after start");
  a_status_readonly: assert property (cfg_rd_in && reg_hit(cfg_addr_in, SYSCTL_OFS)
    |=> cfg_rdata_out[11:9] == $past({seq_link.stream_busy, seq_link.up_busy,
                                      seq_link.down_busy}))
    else $error("status bits differ from sequencer state");
  a_auto_gate: assert property (auto_switch_en_out == $past(ctrl_q[SC_AUTO_BIT]
    && legacy_auto_switch_in)) else $error("auto switch output not gated");
  a_idle_gating: assert property (ctrl_q[SC_GATING_BIT] && card_inserted_in &&
    card_idle_in && card_clk_stopped_in |=> !cb_sm_clk_en_out)
    else $error("idle card state clock not stopped");
  a_lock_write: assert property (sc_wr && cfg_be_in[0] |=> ##1
    identity_wr_en_out == !$past(cfg_wdata_in[SC_LOCK_BIT], 2))
    else $error("identity write enable does not follow lock");
  a_parity_block: assert property (!ctrl_q[SC_PARITY_BIT] |=> !serr_parity_out)
    else $error("parity reported while disabled");
  a_voltage_write: assert property (sc_wr && cfg_be_in[0] |=> ##1
    socket_voltage_select_out == $past(cfg_wdata_in[SC_VOLT_BIT], 2))
    else $error("voltage select does not follow write");
  a_keep_clock: assert property (sc_wr && cfg_be_in[0] |=> ##1
    clock_stop_inhibit_out == $past(cfg_wdata_in[SC_KEEP_BIT], 2))
    else $error("clock stop inhibit does not follow write");
  a_ring_wins: assert property (!ctrl_q[SC_MUX_BIT] && ring_en_in && pme_en_in
    |=> ring_wake_pin_out == $past(ring_indicate_output_in))
    else $error("ring not given the shared pin");
  a_wake_only: assert property (ctrl_q[SC_MUX_BIT] |=> ring_wake_pin_out == $past(pme_in))
    else $error("wake event not alone on shared pin");
  a_routing_top: assert property (pin_routing_out[31:28] == 4'h0)
    else $error("routing top nibble not zero");
  a_eeprom_load: assert property (eeprom_load_in |=> ##1
    pin_routing_out == ($past(eeprom_data_in, 2) & ROUTING_RW_MASK))
    else $error("eeprom load not applied to routing");

  c_eeprom: cover property (eeprom_load_in ##2 pin_routing_out != ROUTING_RESET);
  c_ring_over_wake: cover property (!ctrl_q[SC_MUX_BIT] && ring_en_in && pme_en_in && pme_in);
  c_gated: cover property (!cb_sm_clk_en_out);

endmodule : card_sysctl_routing
`default_nettype wire

// File: bench/card_socket_model.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Card socket model: one interrogation per request, start then done.
module card_socket_model (
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Request from the bench; delay 0 answers promptly.
  input  wire logic       probe_go_in,
  input  wire logic [3:0] probe_dly_in,
  // Interrogation events toward the block.
  output logic            probe_start_out,
  output logic            probe_done_out
);
  logic [4:0] left_q;

  // A new request is ignored while an interrogation is still running.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      left_q          <= 5'h00;
      probe_start_out <= 1'b0;
      probe_done_out  <= 1'b0;
    end else begin
      probe_start_out <= probe_go_in && (left_q == 5'h00);
      probe_done_out  <= (left_q == 5'h01);
      if (probe_go_in && (left_q == 5'h00)) begin
        left_q <= {1'b0, probe_dly_in} + 5'h01;
      end else if (left_q != 5'h00) begin
        left_q <= left_q - 5'h01;
      end
    end
  end
endmodule : card_socket_model
`default_nettype wire

// File: bench/tb_card_ctrl_sysctl_low_and_pin_routing.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
// ============================================================
// Self-checking bench for the system control and pin routing bank.
module tb_card_ctrl_sysctl_low_and_pin_routing;
  import card_ctrl_pkg::*;
  localparam int UPC = 20;
  localparam int DNC = 10;
  // Control byte, inputs {legacy,ins,idle,stop,par,ri,ren,pme,pmeen},
  // outputs {auto,cbclk,idwr,serr,volt,inhibit,pin}. Bit 3 is kept 0.
  typedef struct packed {logic [7:0] c; logic [8:0] i; logic [6:0] o;} row_t;
  localparam row_t ROWS [12] = '{
    '{8'h20, 9'h000, 7'h20},
    '{8'h80, 9'h100, 7'h70},
    '{8'h40, 9'h0E0, 7'h10},
    '{8'h40, 9'h0C0, 7'h30},
    '{8'h30, 9'h010, 7'h28},
    '{8'h20, 9'h010, 7'h20},
    '{8'h26, 9'h000, 7'h26},
    '{8'h20, 9'h007, 7'h20},
    '{8'h20, 9'h00C, 7'h21},
    '{8'h20, 9'h003, 7'h21},
    '{8'h21, 9'h00D, 7'h20},
    '{8'h21, 9'h006, 7'h21}
  };

  // ============================================================
  // Design signals.
  logic        clk_sys_in, reset_n_in, cfg_wr_in, cfg_rd_in, cfg_rvalid_out;
  logic [7:0]  cfg_addr_in;
  logic [3:0]  cfg_be_in, probe_dly;
  logic [31:0] cfg_wdata_in, cfg_rdata_out, eeprom_data_in, pin_routing_out, d;
  logic        pwr_up_req_in, pwr_down_req_in, probe_start_in, probe_done_in;
  logic        legacy_auto_switch_in, card_inserted_in, card_idle_in;
  logic        card_clk_stopped_in, card_parity_err_in, auto_switch_en_out;
  logic        cb_sm_clk_en_out, identity_wr_en_out, serr_parity_out;
  logic        socket_voltage_select_out, clock_stop_inhibit_out;
  logic        ring_indicate_output_in, ring_en_in, pme_in, pme_en_in;
  logic        ring_wake_pin_out, eeprom_load_in, probe_go;
  int          err_total, checks_done, cycles;

  card_sysctl_routing #(.UP_CYC(UPC), .DOWN_CYC(DNC)) card_sysctl_routing_inst (
    .clk_sys_in, .reset_n_in, .cfg_wr_in, .cfg_rd_in, .cfg_addr_in, .cfg_be_in,
    .cfg_wdata_in, .cfg_rdata_out, .cfg_rvalid_out, .pwr_up_req_in,
    .pwr_down_req_in, .probe_start_in, .probe_done_in, .legacy_auto_switch_in,
    .card_inserted_in, .card_idle_in, .card_clk_stopped_in, .card_parity_err_in,
    .auto_switch_en_out, .cb_sm_clk_en_out, .identity_wr_en_out, .serr_parity_out,
    .socket_voltage_select_out, .clock_stop_inhibit_out, .ring_indicate_output_in,
    .ring_en_in, .pme_in, .pme_en_in, .ring_wake_pin_out, .eeprom_load_in,
    .eeprom_data_in, .pin_routing_out);

  card_socket_model card_socket_model_inst (
    .clk_in(clk_sys_in), .rst_n_in(reset_n_in), .probe_go_in(probe_go),
    .probe_dly_in(probe_dly), .probe_start_out(probe_start_in),
    .probe_done_out(probe_done_in));

  // ============================================================
  // Clock and run limit.
  always #20 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ============================================================
  // Bus tasks and sequences.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
    @(posedge clk_sys_in);
    cfg_wr_in    <= 1'b1;
    cfg_addr_in  <= a;
    cfg_be_in    <= b;
    cfg_wdata_in <= v;
    @(posedge clk_sys_in);
    cfg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys_in);
    cfg_rd_in   <= 1'b1;
    cfg_addr_in <= a;
    @(posedge clk_sys_in);
    cfg_rd_in <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, cfg_rvalid_out)
    v = cfg_rdata_out;
  endtask : rd

  // Reads status every cycle and counts busy cycles; extra requests are refused.
  task automatic pwr(input logic up);
    int s, u, w;
    s = 0;
    u = 0;
    w = 0;
    @(posedge clk_sys_in);
    pwr_up_req_in   <= up;
    pwr_down_req_in <= !up;
    cfg_rd_in       <= 1'b1;
    cfg_addr_in     <= SYSCTL_OFS;
    for (int k = 0; k < 90; k++) begin
      @(posedge clk_sys_in);
      pwr_up_req_in   <= (k == 10);
      pwr_down_req_in <= (k == 35);
      #1;
      s += int'(cfg_rdata_out[11]);
      u += int'(cfg_rdata_out[10]);
      w += int'(cfg_rdata_out[9]);
    end
    @(posedge clk_sys_in);
    cfg_rd_in <= 1'b0;
    `CHK("stream", 32, s)
    `CHK("up", (up ? UPC : 0), u)
    `CHK("down", (up ? 0 : DNC), w)
  endtask : pwr

  task automatic probe(input logic [3:0] dl);
    logic [31:0] v;
    @(posedge clk_sys_in);
    probe_go  <= 1'b1;
    probe_dly <= dl;
    @(posedge clk_sys_in);
    probe_go <= 1'b0;
    // Read in the cycle after the start pulse reaches the block; busy from then on.
    rd(SYSCTL_OFS, v);
    `CHK("probe", 1'b1, v[8])
    cyc(int'(dl) + 4);
    rd(SYSCTL_OFS, v);
    `CHK("probe end", 1'b0, v[8])
  endtask : probe

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // ============================================================
  // Main sequence.
  initial begin
    {clk_sys_in, reset_n_in, cfg_wr_in, cfg_rd_in, cfg_addr_in, cfg_be_in} = '0;
    {cfg_wdata_in, eeprom_data_in, eeprom_load_in, probe_go, probe_dly} = '0;
    {pwr_up_req_in, pwr_down_req_in, legacy_auto_switch_in, card_inserted_in} = '0;
    {card_idle_in, card_clk_stopped_in, card_parity_err_in} = '0;
    {ring_indicate_output_in, ring_en_in, pme_in, pme_en_in} = '0;
    {err_total, checks_done, cycles} = '0;
    cyc(4);
    reset_n_in <= 1'b1;
    cyc(4);
    rd(SYSCTL_OFS, d);
    `CHK("sysctl reset", 32'h0000_0020, d)
    rd(ROUTING_OFS, d);
    `CHK("routing reset", 32'h0000_1000, d)
    `CHK("pins reset", 32'h0000_1000, pin_routing_out)
    // Table of control settings against derived outputs.
    foreach (ROWS[n]) begin
      wr(SYSCTL_OFS, 4'h1, {24'h0, ROWS[n].c});
      {legacy_auto_switch_in, card_inserted_in, card_idle_in, card_clk_stopped_in,
       card_parity_err_in, ring_indicate_output_in, ring_en_in, pme_in,
       pme_en_in} <= ROWS[n].i;
      cyc(3);
      #1;
      `CHK("outputs", ROWS[n].o, {auto_switch_en_out, cb_sm_clk_en_out, identity_wr_en_out, serr_parity_out, socket_voltage_select_out, clock_stop_inhibit_out, ring_wake_pin_out})
      rd(SYSCTL_OFS, d);
      `CHK("ctrl", {24'h0, ROWS[n].c}, d)
    end
    // Writes to status bits and upper lanes land nowhere.
    wr(SYSCTL_OFS, 4'hF, 32'hFFFF_0F20);
    rd(SYSCTL_OFS, d);
    `CHK("status write", 32'h0000_0020, d)
    // Lane tests reprogram routing; an ordinary host sets it once at start.
    wr(ROUTING_OFS, 4'hF, 32'hFFFF_FFFF);
    rd(ROUTING_OFS, d);
    `CHK("routing all", 32'h0FFF_FFFF, d)
    wr(ROUTING_OFS, 4'h2, 32'h0000_0000);
    rd(ROUTING_OFS, d);
    `CHK("routing lane", 32'h0FFF_00FF, d)
    rd(8'h84, d);
    `CHK("unmapped", 32'h0, d)
    // Serial EEPROM load replaces the routing contents.
    @(posedge clk_sys_in);
    eeprom_load_in <= 1'b1;
    eeprom_data_in <= 32'h0ABC_1234;
    @(posedge clk_sys_in);
    eeprom_load_in <= 1'b0;
    rd(ROUTING_OFS, d);
    `CHK("eeprom", 32'h0ABC_1234, d)
    `CHK("eeprom pins", 32'h0ABC_1234, pin_routing_out)
    pwr(1'b1);
    pwr(1'b0);
    probe(4'hC);
    probe(4'h0);
    // Unlock the identity registers so that the reset below has something to undo.
    wr(SYSCTL_OFS, 4'h1, 32'h0000_0006);
    cyc(3);
    #1;
    `CHK("pre idwr", 1'b1, identity_wr_en_out)
    // Reset in mid-run returns the outputs at once.
    @(posedge clk_sys_in);
    reset_n_in <= 1'b0;
    cyc(2);
    #1;
    `CHK("rerun pins", 32'h0000_1000, pin_routing_out)
    `CHK("rerun idwr", 1'b0, identity_wr_en_out)
    `CHK("rerun volt", 1'b0, socket_voltage_select_out)
    // After the second release the bank comes back with its reset contents.
    @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    cyc(4);
    rd(SYSCTL_OFS, d);
    `CHK("rerun sysctl", 32'h0000_0020, d)
    rd(ROUTING_OFS, d);
    `CHK("rerun routing", 32'h0000_1000, d)
    tally_and_finish();
  end
endmodule : tb_card_ctrl_sysctl_low_and_pin_routing
`default_nettype wire
